// File: logic/power_seq_pkg.sv
package power_seq_pkg;

	// ----------------------------------------
	// time base
	// ----------------------------------------
	localparam int          CLK_MHZ   = 250;                        // mclk rate
	localparam int          US_PER_MS = 1000;                       // microseconds in one tick
	localparam int          DIV_W     = 18;                         // divider width
	localparam logic [17:0] MS_CYCLES = 18'(CLK_MHZ * US_PER_MS);   // mclk cycles per 1 ms tick

	// ----------------------------------------
	// sequencing periods, in 1 ms ticks
	// ----------------------------------------
	localparam int          CNT_W           = 16;      // period counter width
	localparam logic [15:0] ON_DB_MS        = 16'h0080; // 128 ms turn-on debounce
	localparam logic [15:0] OFF_DB_MS       = 16'h0020; // 32 ms turn-off debounce
	localparam logic [15:0] BLANK_MS        = 16'h0200; // 512 ms power-up blanking
	localparam logic [15:0] TIMEOUT_MS      = 16'h0080; // 128 ms shutdown timeout
	localparam logic [15:0] LOCKOUT_MS      = 16'h0100; // 256 ms enable lockout
	localparam logic [15:0] RELEASE_DB_MS   = 16'h0020; // 32 ms release debounce
	localparam logic [15:0] EXTEND_NONE     = 16'h0000; // no extension configured

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [2:0]  SYNC_RST  = 3'h7;  // synchronisers idle high
	localparam logic [15:0] CNT_RST   = 16'h0000;
	localparam logic [17:0] DIV_RST   = 18'h00000;

	// ----------------------------------------
	// sequencer states, one-hot
	// ----------------------------------------
	typedef enum logic [6:0] {
		ST_OFF_IDLE = 7'h01, // powered off, debouncing a turn-on press
		ST_BLANK    = 7'h02, // enable asserted, inputs ignored
		ST_REL_ON   = 7'h04, // powered, debouncing button release
		ST_ON_IDLE  = 7'h08, // powered, debouncing a turn-off press
		ST_SHUTDOWN = 7'h10, // shutdown requested, timeout running
		ST_LOCKOUT  = 7'h20, // powered off, button ignored
		ST_REL_OFF  = 7'h40  // powered off, debouncing button release
	} seq_state_e;

	// ----------------------------------------
	// whole sequencer state
	// ----------------------------------------
	typedef struct packed {
		seq_state_e  state;    // sequencer state
		logic [15:0] cnt;      // period counter in ticks
		logic [17:0] div;      // tick divider
		logic        tick;     // one-cycle 1 ms enable
		logic [2:0]  btn_sync; // button synchroniser
		logic [2:0]  ack_sync; // acknowledge synchroniser
		logic        btn_lvl;  // filtered button level
		logic        ack_lvl;  // filtered acknowledge level
		logic        on;       // power logically on
		logic        en_pin;   // enable pin level after polarity
		logic        shut_n;   // shutdown request, active low
	} seq_s;

endpackage

// File: logic/pushbutton_power_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - turn on after 128 ms continuous press
// - powered press valid after 32 ms hold
// - off debounce extendable, default 32 ms
// - valid off press drives shutdown request low
// - ignore acknowledge and button during 512 ms blanking
// - acknowledge low at blanking end aborts power-up
// - shutdown timeout 128 ms plus extension releases enable
// - acknowledge low during timeout releases enable immediately
// - acknowledge low in normal operation releases enable
// - button ignored during lockout after release
// - enable polarity selectable by parameter
// - lockout lasts 256 ms
// - any button release restarts debounce timer
// - debounce button release 32 ms before new press
// - reset leaves enable off, request released
module pushbutton_power_sequencer #(
	parameter logic [17:0] tick_cycles         = power_seq_pkg::MS_CYCLES,   // cycles per tick
	parameter logic [15:0] offpress_extend     = power_seq_pkg::EXTEND_NONE, // extra off-press ticks
	parameter logic [15:0] ack_timeout_extend  = power_seq_pkg::EXTEND_NONE, // extra timeout ticks
	parameter logic        enable_active_high  = 1'b1                        // enable pin polarity
) (
	input  wire logic mclk,           // 250 MHz clock
	input  wire logic rst_n,          // async reset, active low
	input  wire logic button_n,       // pushbutton, low when pressed
	input  wire logic ack_n,          // host acknowledge, low to power off
	output logic      enable_out,     // power enable pin
	output logic      shutdown_req_n  // shutdown request to host, active low
);
	import power_seq_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// end of a period: last tick of a count
	function automatic logic period_done(input logic t, input logic [15:0] c, input logic [15:0] lim);
		period_done = t && (c == lim - 16'h0001);
	endfunction

	// off-press hold with extension
	function automatic logic [15:0] off_limit();
		off_limit = OFF_DB_MS + offpress_extend;
	endfunction

	// shutdown timeout with extension
	function automatic logic [15:0] timeout_limit();
		timeout_limit = TIMEOUT_MS + ack_timeout_extend;
	endfunction

	// polarity mapping of the enable pin
	function automatic logic pin_of(input logic on);
		pin_of = enable_active_high ? on : ~on;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	seq_s q_r;    // registered state
	seq_s q_nxt;  // next state

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		q_nxt = q_r;
		// tick divider, one-cycle enable every tick_cycles
		if (q_r.div == tick_cycles - 18'h00001) begin
			q_nxt.div  = DIV_RST;
			q_nxt.tick = 1'b1;
		end else begin
			q_nxt.div  = q_r.div + 18'h00001;
			q_nxt.tick = 1'b0;
		end
		// three-stage synchronisers, level taken when stages two and three agree
		q_nxt.btn_sync = {q_r.btn_sync[1:0], button_n};
		q_nxt.ack_sync = {q_r.ack_sync[1:0], ack_n};
		if (q_r.btn_sync[2] == q_r.btn_sync[1]) begin
			q_nxt.btn_lvl = q_r.btn_sync[2];
		end
		if (q_r.ack_sync[2] == q_r.ack_sync[1]) begin
			q_nxt.ack_lvl = q_r.ack_sync[2];
		end
		// period counter advances on tick
		if (q_r.tick) begin
			q_nxt.cnt = q_r.cnt + 16'h0001;
		end
		case (q_r.state)
			// off: count a continuous press
			ST_OFF_IDLE: begin
				if (q_r.btn_lvl) begin
					q_nxt.cnt = CNT_RST;
				end else if (period_done(q_r.tick, q_r.cnt, ON_DB_MS)) begin
					q_nxt.on    = 1'b1;
					q_nxt.cnt   = CNT_RST;
					q_nxt.state = ST_BLANK;
				end
			end
			// blanking: both inputs ignored until the end
			ST_BLANK: begin
				if (period_done(q_r.tick, q_r.cnt, BLANK_MS)) begin
					q_nxt.cnt = CNT_RST;
					if (!q_r.ack_lvl) begin
						q_nxt.on    = 1'b0;
						q_nxt.state = ST_LOCKOUT;
					end else begin
						q_nxt.state = ST_REL_ON;
					end
				end
			end
			// powered: wait for the button to be released
			ST_REL_ON: begin
				if (!q_r.ack_lvl) begin
					q_nxt.on    = 1'b0;
					q_nxt.cnt   = CNT_RST;
					q_nxt.state = ST_LOCKOUT;
				end else if (!q_r.btn_lvl) begin
					q_nxt.cnt = CNT_RST;
				end else if (period_done(q_r.tick, q_r.cnt, RELEASE_DB_MS)) begin
					q_nxt.cnt   = CNT_RST;
					q_nxt.state = ST_ON_IDLE;
				end
			end
			// powered: watch acknowledge, debounce an off press
			ST_ON_IDLE: begin
				if (!q_r.ack_lvl) begin
					q_nxt.on    = 1'b0;
					q_nxt.cnt   = CNT_RST;
					q_nxt.state = ST_LOCKOUT;
				end else if (q_r.btn_lvl) begin
					q_nxt.cnt = CNT_RST;
				end else if (period_done(q_r.tick, q_r.cnt, off_limit())) begin
					q_nxt.shut_n = 1'b0;
					q_nxt.cnt    = CNT_RST;
					q_nxt.state  = ST_SHUTDOWN;
				end
			end
			// shutdown requested: acknowledge or timeout removes power
			ST_SHUTDOWN: begin
				if (!q_r.ack_lvl) begin
					q_nxt.on     = 1'b0;
					q_nxt.shut_n = 1'b1;
					q_nxt.cnt    = CNT_RST;
					q_nxt.state  = ST_LOCKOUT;
				end else if (period_done(q_r.tick, q_r.cnt, timeout_limit())) begin
					q_nxt.on     = 1'b0;
					q_nxt.shut_n = 1'b1;
					q_nxt.cnt    = CNT_RST;
					q_nxt.state  = ST_LOCKOUT;
				end
			end
			// power removed: button ignored for the lockout
			ST_LOCKOUT: begin
				if (period_done(q_r.tick, q_r.cnt, LOCKOUT_MS)) begin
					q_nxt.cnt   = CNT_RST;
					q_nxt.state = ST_REL_OFF;
				end
			end
			// power removed: wait for the button to be released
			ST_REL_OFF: begin
				if (!q_r.btn_lvl) begin
					q_nxt.cnt = CNT_RST;
				end else if (period_done(q_r.tick, q_r.cnt, RELEASE_DB_MS)) begin
					q_nxt.cnt   = CNT_RST;
					q_nxt.state = ST_OFF_IDLE;
				end
			end
			// unreachable code point, recover to off
			default: begin
				q_nxt.on     = 1'b0;
				q_nxt.shut_n = 1'b1;
				q_nxt.cnt    = CNT_RST;
				q_nxt.state  = ST_OFF_IDLE;
			end
		endcase
		q_nxt.en_pin = pin_of(q_nxt.on);
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q_r.state    <= ST_OFF_IDLE;
			q_r.cnt      <= CNT_RST;
			q_r.div      <= DIV_RST;
			q_r.tick     <= 1'b0;
			q_r.btn_sync <= SYNC_RST;
			q_r.ack_sync <= SYNC_RST;
			q_r.btn_lvl  <= 1'b1;
			q_r.ack_lvl  <= 1'b1;
			q_r.on       <= 1'b0;
			q_r.en_pin   <= ~enable_active_high;
			q_r.shut_n   <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	// outputs straight from flip-flops
	assign enable_out     = q_r.en_pin;
	assign shutdown_req_n = q_r.shut_n;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_turn_on;
		$rose(q_r.on) |-> $past(q_r.state) == ST_OFF_IDLE && $past(q_r.cnt) == ON_DB_MS - 16'h0001;
	endproperty
	a_turn_on: assert property (p_turn_on) else $error("enable rose without full turn-on debounce");

	property p_off_press;
		$fell(q_r.shut_n) |-> $past(q_r.cnt) == off_limit() - 16'h0001 && !$past(q_r.btn_lvl);
	endproperty
	a_off_press: assert property (p_off_press) else $error("request fell without full off debounce");

	property p_req_held;
		q_r.state == ST_SHUTDOWN |-> !shutdown_req_n && q_r.on;
	endproperty
	a_req_held: assert property (p_req_held) else $error("request not low while shutting down");

	property p_blank_hold;
		(q_r.state == ST_BLANK && !period_done(q_r.tick, q_r.cnt, BLANK_MS)) |=> q_r.on && q_r.state == ST_BLANK;
	endproperty
	a_blank_hold: assert property (p_blank_hold) else $error("inputs acted during blanking");

	property p_abort;
		(q_r.state == ST_BLANK && period_done(q_r.tick, q_r.cnt, BLANK_MS) && !q_r.ack_lvl) |=> !q_r.on ##1 !q_r.on;
	endproperty
	a_abort: assert property (p_abort) else $error("power-up not aborted");

	property p_timeout;
		(q_r.state == ST_SHUTDOWN && q_r.ack_lvl && period_done(q_r.tick, q_r.cnt, timeout_limit()))
			|=> !q_r.on && q_r.state == ST_LOCKOUT;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not release enable");

	property p_ack_kill;
		(q_r.state == ST_SHUTDOWN && !q_r.ack_lvl) |=> !q_r.on && shutdown_req_n;
	endproperty
	a_ack_kill: assert property (p_ack_kill) else $error("acknowledge did not stop timeout");

	property p_ack_normal;
		(q_r.state == ST_ON_IDLE && $fell(ack_n)) ##1 !ack_n [*4] |-> ##[0:4] !q_r.on;
	endproperty
	a_ack_normal: assert property (p_ack_normal) else $error("acknowledge low did not release enable");

	property p_lockout;
		q_r.state == ST_LOCKOUT |=> !q_r.on && $stable(q_r.en_pin);
	endproperty
	a_lockout: assert property (p_lockout) else $error("enable moved during lockout");

	property p_pin;
		enable_out == (enable_active_high ? q_r.on : !q_r.on);
	endproperty
	a_pin: assert property (p_pin) else $error("enable pin polarity wrong");

	property p_debounce_reset;
		(q_r.state == ST_OFF_IDLE && q_r.btn_lvl) |=> q_r.cnt == CNT_RST;
	endproperty
	a_debounce_reset: assert property (p_debounce_reset) else $error("debounce not restarted");

	property p_release;
		$rose(q_r.state == ST_ON_IDLE) |-> $past(q_r.state) == ST_REL_ON && $past(q_r.btn_lvl);
	endproperty
	a_release: assert property (p_release) else $error("release not debounced");

	property p_req_idle;
		!q_r.on |-> shutdown_req_n;
	endproperty
	a_req_idle: assert property (p_req_idle) else $error("request low while powered off");

endmodule // pushbutton_power_sequencer

// File: verif/host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host processor on the handshake pins
// ----------------------------------------
module host_model #(
	parameter int boot_cycles  = 100, // cycles from power-up to ack high
	parameter int reply_cycles = 40   // cycles from request to ack low
) (
	input  wire logic mclk,           // bench clock
	input  wire logic rst_n,          // async reset, active low
	input  wire logic powered,        // host supply present
	input  wire logic shutdown_req_n, // request from sequencer
	input  wire logic stay_down,      // host fails to boot
	input  wire logic answer,         // host answers a request
	input  wire logic kill_req,       // host orders power off
	output logic      ack_n           // acknowledge, low to power off
);
	logic [15:0] cnt_r; // cycles since power-up up to boot_cycles, then counts on only during a reply

	// an unpowered or hung host leaves ack low
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_n <= 1'b0;
			cnt_r <= 16'h0000;
		end else if (!powered || stay_down) begin
			ack_n <= 1'b0;
			cnt_r <= 16'h0000;
		end else if (cnt_r < 16'(boot_cycles)) begin
			cnt_r <= cnt_r + 16'h0001;
			ack_n <= (cnt_r == 16'(boot_cycles - 1));
		end else if (kill_req || (!shutdown_req_n && answer)) begin
			// ack then held low until power is gone, far past 30 us
			if (cnt_r == 16'(boot_cycles + reply_cycles))
				ack_n <= 1'b0;
			else
				cnt_r <= cnt_r + 16'h0001;
		end
	end
endmodule // host_model

// File: verif/testbench.sv
`timescale 1ns/1ps
`define CHK(g,e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	import power_seq_pkg::*;
	localparam int T  = 4;  // cycles per tick
	localparam int RP = 40; // host reply cycles
	logic mclk, rst_n, button_n, stay_down, answer, kill_req;
	logic ack_n, enable_out, en_low, shutdown_req_n, req_low_n, on_w;
	int   mismatches, total_checks;
	assign on_w = (enable_out === 1'b1);

	pushbutton_power_sequencer #(.tick_cycles(18'(T))) dut (.mclk(mclk), .rst_n(rst_n),
		.button_n(button_n), .ack_n(ack_n), .enable_out(enable_out), .shutdown_req_n(shutdown_req_n));
	// low-true twin, sequencing must match
	pushbutton_power_sequencer #(.tick_cycles(18'(T)), .enable_active_high(1'b0)) dut_low (
		.mclk(mclk), .rst_n(rst_n), .button_n(button_n), .ack_n(ack_n), .enable_out(en_low),
		.shutdown_req_n(req_low_n));
	host_model #(.reply_cycles(RP)) host (.mclk(mclk), .rst_n(rst_n), .powered(on_w),
		.shutdown_req_n(shutdown_req_n), .stay_down(stay_down), .answer(answer),
		.kill_req(kill_req), .ack_n(ack_n));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cy(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic tk(input int n);
		cy(n * T);
	endtask
	// cycles until enable (s=0) or request (s=1) reaches lvl
	task automatic wt(input logic s, input logic lvl, input int lo, input int hi);
		int n;
		n = 0;
		while (((s ? shutdown_req_n : on_w) !== lvl) && n < 9999) begin
			cy(1);
			n++;
		end
		`CHK(n >= lo && n <= hi, 1'b1)
		`CHK(en_low, ~enable_out)
		`CHK(req_low_n, shutdown_req_n)
	endtask
	// press, hold past blanking end, release, settle
	task automatic power_on;
		button_n = 1'b0;
		wt(1'b0, 1'b1, 127 * T, 128 * T + 6);
		tk(560);
		`CHK(on_w, 1'b1)
		`CHK(shutdown_req_n, 1'b1)
		button_n = 1'b1;
		tk(40);
		`CHK(on_w, 1'b1)
	endtask
	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_reset_bounce;
		`CHK(enable_out, 1'b0)
		`CHK(shutdown_req_n, 1'b1)
		button_n = 1'b0;
		tk(100);
		button_n = 1'b1;
		tk(2);
		`CHK(enable_out, 1'b0)
		power_on();
		$display("reset and bounce done");
	endtask
	task automatic s_timeout_lockout;
		button_n = 1'b0;
		wt(1'b1, 1'b0, 31 * T, 32 * T + 6);
		button_n = 1'b1;
		wt(1'b0, 1'b0, 127 * T, 128 * T + 6);
		`CHK(shutdown_req_n, 1'b1)
		// press late in the lockout: a short or missing lockout would power up
		tk(250);
		button_n = 1'b0;
		tk(154);
		`CHK(enable_out, 1'b0)
		button_n = 1'b1;
		tk(40);
		power_on();
		$display("timeout and lockout done");
	endtask
	task automatic s_answer;
		answer = 1'b1;
		button_n = 1'b0;
		wt(1'b1, 1'b0, 31 * T, 32 * T + 6);
		button_n = 1'b1;
		wt(1'b0, 1'b0, RP, RP + 10);
		`CHK(shutdown_req_n, 1'b1)
		answer = 1'b0;
		tk(300);
		$display("answered shutdown done");
	endtask
	task automatic s_kill_abort;
		power_on();
		kill_req = 1'b1;
		wt(1'b0, 1'b0, RP, RP + 10);
		`CHK(shutdown_req_n, 1'b1)
		kill_req = 1'b0;
		tk(300);
		stay_down = 1'b1;
		button_n = 1'b0;
		wt(1'b0, 1'b1, 127 * T, 128 * T + 6);
		button_n = 1'b1;
		wt(1'b0, 1'b0, 511 * T, 512 * T + 6);
		stay_down = 1'b0;
		$display("kill and abort done");
	endtask

	// ----------------------------------------
	// clock, stimulus, watchdog
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		rst_n = 1'b0;
		button_n = 1'b1;
		stay_down = 1'b0;
		answer = 1'b0;
		kill_req = 1'b0;
		mismatches = 0;
		total_checks = 0;
		cy(4);
		rst_n = 1'b1;
		cy(1);
		s_reset_bounce();
		s_timeout_lockout();
		s_answer();
		s_kill_abort();
		end_of_test();
	end
	initial begin
		repeat (60000) @(posedge mclk);
		mismatches++;
		end_of_test();
	end
endmodule // testbench
